// file: hdl/fc_els_pkg.sv
// constants and types for the link error and capability responder
package fc_els_pkg;
    localparam int CLK_MHZ = 40;
    localparam logic [7:0] CMD_RLS = 8'h0F;
    localparam logic [7:0] CMD_RNC = 8'h53;
    localparam logic [7:0] ACC_CODE = 8'h02;
    localparam logic [7:0] RSN_LOGICAL = 8'h03;
    localparam logic [7:0] EXPL_LOGICAL = 8'h2A;
    localparam logic [23:0] SEL_RX = 24'h00_0000;
    localparam logic [23:0] SEL_A = 24'h00_0001;
    localparam logic [23:0] SEL_B = 24'h00_0002;
    localparam logic [8:0] IDX_CMD = 9'h000;
    localparam logic [8:0] IDX_RSV_LO = 9'h001;
    localparam logic [8:0] IDX_RSV_HI = 9'h003;
    localparam logic [8:0] IDX_SEL_LO = 9'h005;
    localparam logic [8:0] IDX_SEL_HI = 9'h007;
    localparam logic [8:0] IDX_LEN_HI = 9'h002;
    localparam logic [8:0] IDX_LEN_LO = 9'h003;
    localparam logic [8:0] IDX_FLAGS = 9'h004;
    localparam logic [8:0] IDX_VULEN = 9'h007;
    localparam logic [8:0] IDX_VID = 9'h008;
    localparam logic [8:0] IDX_ENTRY = 9'h010;
    localparam logic [8:0] IDX_RJT_RSN = 9'h005;
    localparam logic [8:0] IDX_RJT_EXPL = 9'h006;
    localparam logic [15:0] RNC_MIN_LEN = 16'h0010;
    localparam logic [15:0] RNC_MAX_LEN = 16'h0100;
    localparam logic [7:0] VU_MAX = 8'h80;
    localparam logic [15:0] ENTRY_LEN = 16'h0004;
    localparam logic [15:0] EXT_LEN_HI = 16'h0006;
    localparam logic [15:0] EXT_LEN_LO = 16'h0007;
    localparam int SELECT_BIT = 7;
    localparam int EXT_BIT = 6;
    localparam int VU_HI = 5;
    localparam int VU_LO = 4;
    localparam logic [1:0] VU_RESERVED = 2'b11;
    localparam int NUM_DOCS = 4;
    localparam logic [7:0] DOC_IDS [NUM_DOCS] = '{8'h04, 8'h13, 8'h25, 8'h26};
    localparam logic [8:0] RLS_ACC_LEN = 9'h01C;
    localparam logic [8:0] RNC_ACC_LEN = 9'h020;
    localparam logic [8:0] RJT_LEN = 9'h008;
    localparam logic [8:0] HDR_LEN = 9'h004;
    localparam int NUM_CNT = 6;
    localparam logic [2:0] CNT_LINK = 3'd0;
    localparam logic [2:0] CNT_SYNC = 3'd1;
    localparam logic [2:0] CNT_SIG = 3'd2;
    localparam logic [2:0] CNT_PSP = 3'd3;
    localparam logic [2:0] CNT_ITW = 3'd4;
    localparam logic [2:0] CNT_CRC = 3'd5;
    localparam logic [7:0] REG_CTRL = 8'h30;
    localparam int CTRL_LIP_EN = 0;
    typedef struct packed {
        logic outOfSync;
        logic invalidWord;
        logic crcBad;
        logic [15:0] nexusTag;
    } rx_event_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic port;
    } byte_beat_t;
endpackage : fc_els_pkg

// file: hdl/link_error_and_capability_responder.sv
// link error counters with error-status and capability request responder
//
// Summary of operation
// - each of the two loop ports keeps its own independent error counter set
// - counters wrap to zero past their maximum value
// - counters clear only at power-up, never by requests or system reset
// - error-status request with nonzero bytes 1-3 gets command-unsupported reject
// - selector 0 means receiving port, 1 first port, 2 second port
// - error-status accept is word 0200_0000 then 24-byte counter block
// - block holds six big-endian 4-byte counters in the fixed order
// - link failure counted when out of sync for the whole timeout
// - link failure requests failure-code loop initialization on that port
// - every loss of synchronization counts, however brief
// - signal-loss and sequence-error counters are not maintained
// - each invalid transmission word increments that port's counter
// - successive bad CRCs on the same command nexus counted only once
// - capability request code 53h, accept starts with 02
// - request length 16 to 256 bytes; reply never exceeds 256 bytes
// - select flag set gets reject reason 03h explanation 2Ah
// - vendor information length up to 128 bytes is handled
// - reply carries eight ASCII vendor identifier bytes
// - entry invalidate and preference bits are ignored
// - entries are 4 bytes plus extension; replies use plain 4-byte entries
// - entry bits 5-4 decode standard, sender, receiver unique, reserved
// - only document identifiers 04h, 13h, 25h, 26h are reported
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module link_error_and_capability_responder
    import fc_els_pkg::*;
#(
    parameter int RTTOV_US = 100000,
    parameter int RTTOV_CYC = RTTOV_US * CLK_MHZ,
    parameter logic [63:0] VENDOR_ID = 64'h5645_4E44_4F52_2020, // arbitrary value
    parameter logic [7:0] REV_LO = 8'h00,
    parameter logic [7:0] REV_HI = 8'h00,
    parameter logic [7:0] LSRJT_CODE = 8'h01,
    parameter logic [7:0] RSN_UNSUPPORTED = 8'h0B,
    parameter logic [7:0] EXPL_NONE = 8'h00
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic porRst,
    input wire rx_event_t rxEvent [2],
    input wire byte_beat_t req,
    output byte_beat_t rsp,
    output logic reqReady,
    output logic [1:0] lipF8,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata
);
    typedef enum {ST_PARSE, ST_DECIDE, ST_SEND} state_t;
    typedef enum {RPL_RLS, RPL_RNC, RPL_RJT} reply_t;

    function automatic logic [31:0] shownCount(input logic [2:0] c, input logic [31:0] w);
        shownCount = (c == CNT_SIG || c == CNT_PSP) ? 32'h0000_0000 : w;
    endfunction : shownCount

    logic [31:0] errCnt [2][NUM_CNT];
    logic [31:0] rtTimer [2];
    logic [1:0] failDone;
    logic [1:0] syncPrev;
    logic [1:0] linkFail;
    logic [1:0] crcSeen;
    logic [15:0] crcTag [2];
    logic lipEnable;

    state_t state;
    reply_t kind;
    logic [8:0] rxIdx;
    logic [8:0] txIdx;
    logic [8:0] txLen;
    logic [7:0] cmd;
    logic rsvBad;
    logic [23:0] portSel;
    logic rxPort;
    logic cntPort;
    logic [15:0] payLen;
    logic [7:0] rncFlags;
    logic [7:0] vuLen;
    logic [15:0] entryPos;
    logic [7:0] extHi;
    logic entryExt;
    logic entryBad;
    logic [7:0] rjtRsn;
    logic [7:0] rjtExpl;
    logic [7:0] txByte;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            linkFail[p] = rxEvent[p].outOfSync && !failDone[p]
                && rtTimer[p] == 32'(RTTOV_CYC - 1);
        end
    end

    // timeout tracking per port; system reset clears this but not the counters
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            failDone <= 2'b00;
            syncPrev <= 2'b00;
            lipF8 <= 2'b00;
            for (int p = 0; p < 2; p++) begin
                rtTimer[p] <= 32'h0000_0000;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                syncPrev[p] <= rxEvent[p].outOfSync;
                lipF8[p] <= linkFail[p] && lipEnable;
                if (!rxEvent[p].outOfSync) begin
                    rtTimer[p] <= 32'h0000_0000;
                    failDone[p] <= 1'b0;
                end else if (linkFail[p]) begin
                    failDone[p] <= 1'b1;
                end else if (!failDone[p]) begin
                    rtTimer[p] <= rtTimer[p] + 32'h0000_0001;
                end
            end
        end
    end

    // error counters: cleared by power-on reset alone, wrap on overflow
    always_ff @(posedge clk) begin
        if (porRst) begin
            crcSeen <= 2'b00;
            for (int p = 0; p < 2; p++) begin
                crcTag[p] <= 16'h0000;
                for (int c = 0; c < NUM_CNT; c++) begin
                    errCnt[p][c] <= 32'h0000_0000;
                end
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (linkFail[p]) begin
                    errCnt[p][CNT_LINK] <= errCnt[p][CNT_LINK] + 32'h0000_0001;
                end
                if (rxEvent[p].outOfSync && !syncPrev[p]) begin
                    errCnt[p][CNT_SYNC] <= errCnt[p][CNT_SYNC] + 32'h0000_0001;
                end
                if (rxEvent[p].invalidWord) begin
                    errCnt[p][CNT_ITW] <= errCnt[p][CNT_ITW] + 32'h0000_0001;
                end
                if (rxEvent[p].crcBad && (!crcSeen[p] || crcTag[p] != rxEvent[p].nexusTag)) begin
                    errCnt[p][CNT_CRC] <= errCnt[p][CNT_CRC] + 32'h0000_0001;
                    crcTag[p] <= rxEvent[p].nexusTag;
                    crcSeen[p] <= 1'b1;
                end
            end
        end
    end

    // software port: counter readback and control
    always_ff @(posedge clk) begin
        logic [5:0] w;
        logic hiPort;
        logic [2:0] c;
        w = regAddr[7:2];
        hiPort = w >= 6'(NUM_CNT);
        c = hiPort ? 3'(w - 6'(NUM_CNT)) : w[2:0];
        if (sys_rst) begin
            lipEnable <= 1'b1;
            regRdata <= 32'h0000_0000;
        end else begin
            if (regWr && regAddr == REG_CTRL) begin
                lipEnable <= regWdata[CTRL_LIP_EN];
            end
            if (!regRd) begin
                regRdata <= 32'h0000_0000;
            end else if (regAddr == REG_CTRL) begin
                regRdata <= {31'h0000_0000, lipEnable};
            end else if (regAddr < REG_CTRL && regAddr[1:0] == 2'b00) begin
                regRdata <= shownCount(c, errCnt[hiPort][c]);
            end else begin
                regRdata <= 32'h0000_0000;
            end
        end
    end

    // request intake and field capture
    always_ff @(posedge clk) begin
        if (sys_rst || state != ST_PARSE) begin
            rxIdx <= 9'h000;
            rsvBad <= 1'b0;
            entryBad <= 1'b0;
            entryExt <= 1'b0;
            entryPos <= 16'(IDX_ENTRY);
            portSel <= SEL_RX;
            payLen <= 16'h0000;
            rncFlags <= 8'h00;
            vuLen <= 8'h00;
            extHi <= 8'h00;
            cmd <= 8'h00;
        end else if (req.valid && reqReady) begin
            rxIdx <= (rxIdx == 9'h1FF) ? rxIdx : rxIdx + 9'h001;
            if (rxIdx == IDX_CMD) begin
                cmd <= req.data;
                rxPort <= req.port;
            end
            if (cmd == CMD_RLS) begin
                if (rxIdx >= IDX_RSV_LO && rxIdx <= IDX_RSV_HI && req.data != 8'h00) begin
                    rsvBad <= 1'b1;
                end
                if (rxIdx >= IDX_SEL_LO && rxIdx <= IDX_SEL_HI) begin
                    portSel <= {portSel[15:0], req.data};
                end
            end
            if (cmd == CMD_RNC) begin
                if (rxIdx == IDX_LEN_HI) begin
                    payLen[15:8] <= req.data;
                end
                if (rxIdx == IDX_LEN_LO) begin
                    payLen[7:0] <= req.data;
                end
                if (rxIdx == IDX_FLAGS) begin
                    rncFlags <= req.data;
                end
                if (rxIdx == IDX_VULEN) begin
                    vuLen <= req.data;
                end
                if (rxIdx >= IDX_ENTRY && 16'(rxIdx) < payLen - 16'(vuLen)) begin
                    if (16'(rxIdx) == entryPos) begin
                        if (req.data[VU_HI:VU_LO] == VU_RESERVED) begin
                            entryBad <= 1'b1;
                        end
                        entryExt <= req.data[EXT_BIT];
                        if (!req.data[EXT_BIT]) begin
                            entryPos <= entryPos + ENTRY_LEN;
                        end
                    end
                    if (entryExt && 16'(rxIdx) == entryPos + EXT_LEN_HI) begin
                        extHi <= req.data;
                    end
                    if (entryExt && 16'(rxIdx) == entryPos + EXT_LEN_LO) begin
                        entryPos <= entryPos + ENTRY_LEN + {extHi, req.data};
                        entryExt <= 1'b0;
                    end
                end
            end
        end
    end

    // request decision and reply sequencing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_PARSE;
            kind <= RPL_RJT;
            txIdx <= 9'h000;
            txLen <= RJT_LEN;
            cntPort <= 1'b0;
            rjtRsn <= 8'h00;
            rjtExpl <= 8'h00;
        end else begin
            unique case (state)
                ST_PARSE: begin
                    txIdx <= 9'h000;
                    if (req.valid && req.last && reqReady) begin
                        state <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    state <= ST_SEND;
                    kind <= RPL_RJT;
                    txLen <= RJT_LEN;
                    rjtRsn <= RSN_UNSUPPORTED;
                    rjtExpl <= EXPL_NONE;
                    if (cmd == CMD_RLS) begin
                        if (!rsvBad && portSel <= SEL_B) begin
                            kind <= RPL_RLS;
                            txLen <= RLS_ACC_LEN;
                        end
                        cntPort <= (portSel == SEL_RX) ? rxPort : (portSel == SEL_B);
                    end else if (cmd == CMD_RNC) begin
                        rjtRsn <= RSN_LOGICAL;
                        rjtExpl <= EXPL_LOGICAL;
                        if (!rncFlags[SELECT_BIT] && payLen >= RNC_MIN_LEN
                            && payLen <= RNC_MAX_LEN && vuLen <= VU_MAX
                            && !entryBad) begin
                            kind <= RPL_RNC;
                            txLen <= RNC_ACC_LEN;
                        end
                    end else begin
                        state <= ST_PARSE;
                    end
                end
                ST_SEND: begin
                    txIdx <= txIdx + 9'h001;
                    if (txIdx == txLen - 9'h001) begin
                        state <= ST_PARSE;
                    end
                end
            endcase
        end
    end

    // reply byte at the current position; entry flags stay zero, ignoring request flags
    always_comb begin
        logic [8:0] off;
        logic [2:0] c;
        logic [31:0] w;
        off = txIdx - HDR_LEN;
        c = off[4:2];
        w = shownCount(c, errCnt[cntPort][c]);
        txByte = 8'h00;
        unique case (kind)
            RPL_RLS: begin
                if (txIdx == IDX_CMD) begin
                    txByte = ACC_CODE;
                end else if (txIdx >= HDR_LEN) begin
                    txByte = w[8 * (3 - off[1:0]) +: 8];
                end
            end
            RPL_RNC: begin
                off = txIdx - IDX_ENTRY;
                if (txIdx == IDX_CMD) begin
                    txByte = ACC_CODE;
                end else if (txIdx == IDX_LEN_LO) begin
                    txByte = RNC_ACC_LEN[7:0];
                end else if (txIdx >= IDX_VID && txIdx < IDX_ENTRY) begin
                    txByte = VENDOR_ID[8 * (7 - txIdx[2:0]) +: 8];
                end else if (txIdx >= IDX_ENTRY) begin
                    unique case (off[1:0])
                        2'd0: txByte = 8'h00;
                        2'd1: txByte = DOC_IDS[off[3:2]];
                        2'd2: txByte = REV_LO;
                        2'd3: txByte = REV_HI;
                    endcase
                end
            end
            RPL_RJT: begin
                if (txIdx == IDX_CMD) begin
                    txByte = LSRJT_CODE;
                end else if (txIdx == IDX_RJT_RSN) begin
                    txByte = rjtRsn;
                end else if (txIdx == IDX_RJT_EXPL) begin
                    txByte = rjtExpl;
                end
            end
        endcase
    end

    // registered reply stream and intake readiness
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp <= '0;
            reqReady <= 1'b0;
        end else begin
            rsp.valid <= state == ST_SEND;
            rsp.data <= (state == ST_SEND) ? txByte : 8'h00;
            rsp.last <= state == ST_SEND && txIdx == txLen - 9'h001;
            rsp.port <= (state == ST_SEND) ? rxPort : 1'b0;
            reqReady <= state == ST_PARSE && !(req.valid && req.last && reqReady);
        end
    end
endmodule : link_error_and_capability_responder

// file: tb/els_initiator_model.sv
// initiator side model: sends request payloads and collects reply bytes
`timescale 1ns/100ps
module els_initiator_model
    import fc_els_pkg::*;
(
    input wire logic clk,
    input wire logic reqReady,
    input wire byte_beat_t rsp,
    output byte_beat_t req
);
    logic [7:0] rxq [$];
    logic rxPort;
    logic gotLast;
    int stalls = 0;
    initial req = '0;
    always @(posedge clk) begin
        if (rsp.valid === 1'b1) begin
            rxq.push_back(rsp.data);
            rxPort = rsp.port;
            gotLast = rsp.last;
        end
    end
    // byte held until an edge that sees reqReady high; one request at a time
    task automatic send(input logic [7:0] b [$], input logic p);
        int t;
        logic rdy;
        rxq.delete();
        gotLast = 1'b0;
        for (int i = 0; i < b.size(); i++) begin
            req <= '{1'b1, b[i], i == b.size() - 1, p};
            t = 0;
            do begin
                @(negedge clk);
                rdy = reqReady;
                @(posedge clk);
                t++;
            end while (rdy !== 1'b1 && t < 200);
            if (rdy !== 1'b1) stalls++;
        end
        req <= '{1'b0, ~b[b.size() - 1], 1'b0, p};
    endtask : send
endmodule : els_initiator_model

// file: tb/link_error_and_capability_responder_assertions.sv
// port assertions for the link error and capability responder
`timescale 1ns/100ps
module link_error_and_capability_responder_assertions
    import fc_els_pkg::*;
#(
    parameter logic [7:0] LSRJT_CODE = 8'h01
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic porRst,
    input wire rx_event_t rxEvent [2],
    input wire byte_beat_t req,
    input wire byte_beat_t rsp,
    input wire logic reqReady,
    input wire logic [1:0] lipF8,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [8:0] beats;
    // reply beats seen so far
    always_ff @(posedge clk) begin
        if (sys_rst || (rsp.valid && rsp.last)) begin
            beats <= '0;
        end else if (rsp.valid) begin
            beats <= beats + 9'h001;
        end
    end
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
        else $error("read data outside its slot");
    lip_cause_a: assert property (lipF8[1] |-> $past(rxEvent[1].outOfSync))
        else $error("failure primitive without loss of sync");
    lip_pulse_a: assert property (lipF8[1] |=> !lipF8[1])
        else $error("failure primitive longer than one cycle");
    lip_early_a: assert property ($rose(rxEvent[1].outOfSync) |=> !lipF8[1] [*8])
        else $error("link failure before timeout");
    reply_lat_a: assert property ($rose(rsp.valid) |-> $past(req.valid && req.last, 3))
        else $error("reply start not three cycles after request end");
    reply_code_a: assert property ($rose(rsp.valid) |->
        rsp.data == ACC_CODE || rsp.data == LSRJT_CODE)
        else $error("reply starts with wrong code");
    reply_len_a: assert property (rsp.valid && rsp.last |->
        beats == 9'h01B || beats == 9'h01F || beats == 9'h007)
        else $error("reply length wrong");
    reply_run_a: assert property (rsp.valid && !rsp.last |=> rsp.valid && $stable(rsp.port))
        else $error("reply not contiguous");
    reply_busy_a: assert property (rsp.valid |-> !reqReady)
        else $error("ready during reply");
endmodule : link_error_and_capability_responder_assertions
bind link_error_and_capability_responder link_error_and_capability_responder_assertions #(
    .LSRJT_CODE(LSRJT_CODE)
) i_chk (
    .clk(clk), .sys_rst(sys_rst), .porRst(porRst), .rxEvent(rxEvent), .req(req),
    .rsp(rsp), .reqReady(reqReady), .lipF8(lipF8), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata)
);

// file: tb/link_error_and_capability_responder_test.sv
// self-checking bench for the link error and capability responder
`timescale 1ns/100ps
module link_error_and_capability_responder_test
    import fc_els_pkg::*;
;
    localparam int RTT = 20;
    localparam logic [63:0] VID = 64'h4142_4344_4546_4748; // arbitrary value
    logic clk;
    logic sys_rst;
    logic porRst;
    rx_event_t rxEvent [2];
    byte_beat_t req;
    byte_beat_t rsp;
    logic reqReady;
    logic [1:0] lipF8;
    logic [7:0] regAddr;
    logic regWr;
    logic regRd;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    int miscompares = 0;
    int num_checks = 0;
    int lip [2] = '{0, 0};
    logic [7:0] cA [6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h03, 8'h02};
    logic [7:0] cB [6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01};
    logic [7:0] msg [$];
    logic [7:0] exp [$];
    link_error_and_capability_responder #(
        .RTTOV_CYC(RTT), .VENDOR_ID(VID), .REV_LO(8'h01), .REV_HI(8'h02)
    ) i_dut (
        .clk(clk), .sys_rst(sys_rst), .porRst(porRst), .rxEvent(rxEvent), .req(req),
        .rsp(rsp), .reqReady(reqReady), .lipF8(lipF8), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata)
    );
    els_initiator_model i_init (.clk(clk), .reqReady(reqReady), .rsp(rsp), .req(req));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (lipF8[0] === 1'b1) lip[0]++;
        if (lipF8[1] === 1'b1) lip[1]++;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        check(regRdata, want);
        @(posedge clk);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rdcnt(input int p);
        for (int i = 0; i < 6; i++) rd(8'(p * 24 + i * 4), {24'h00_0000, p ? cB[i] : cA[i]});
    endtask : rdcnt
    task automatic pulse(input int p, input logic w, input logic c, input logic [15:0] tag);
        rxEvent[p].invalidWord <= w;
        rxEvent[p].crcBad <= c;
        rxEvent[p].nexusTag <= tag;
        @(posedge clk);
        rxEvent[p].invalidWord <= 1'b0;
        rxEvent[p].crcBad <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic rls(input logic [7:0] b1, input logic [7:0] s);
        msg = {CMD_RLS, b1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, s};
    endtask : rls
    task automatic mkrnc(input logic [15:0] len, input logic [7:0] fl, input logic [7:0] vl);
        msg = {CMD_RNC, 8'h00, len[15:8], len[7:0], fl, 8'h00, 8'h00, vl};
        repeat (8) msg.push_back(8'h41);
    endtask : mkrnc
    task automatic pushrj(input logic [7:0] r, input logic [7:0] e);
        exp = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, r, e, 8'h00};
    endtask : pushrj
    task automatic pushacc();
        exp = {ACC_CODE, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 7; i >= 0; i--) exp.push_back(VID[i * 8 +: 8]);
        for (int k = 0; k < NUM_DOCS; k++) exp = {exp, 8'h00, DOC_IDS[k], 8'h01, 8'h02};
    endtask : pushacc
    task automatic xact(input logic p);
        int t;
        i_init.send(msg, p);
        t = 0;
        while (i_init.gotLast !== 1'b1 && t < 100) begin
            @(posedge clk);
            t++;
        end
        if (i_init.gotLast !== 1'b1 || i_init.stalls != 0) begin
            miscompares++;
            $display("MISMATCH at %0t: reply end got %h expected %h", $time, i_init.gotLast, 1'b1);
            tally_and_finish();
        end
        check(i_init.rxq.size(), exp.size());
        for (int i = 0; i < exp.size() && i < i_init.rxq.size(); i++) check(i_init.rxq[i], exp[i]);
        check(i_init.rxPort, p);
    endtask : xact
    initial begin
        sys_rst = 1'b1;
        porRst = 1'b1;
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWdata = 32'h0000_0000;
        rxEvent[0] = '0;
        rxEvent[1] = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        porRst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 12; a++) rd(8'(a * 4), 32'h0000_0000);
        rd(8'h30, 32'h0000_0001);
        wr(8'h30, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        wr(8'h30, 32'h0000_0001);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0000_0000);
        rd(8'h34, 32'h0000_0000);
        $display("registers test done");
        repeat (2) begin
            rxEvent[0].outOfSync <= 1'b1;
            @(posedge clk);
            rxEvent[0].outOfSync <= 1'b0;
            @(posedge clk);
        end
        repeat (3) pulse(0, 1'b1, 1'b0, 16'h0000);
        pulse(0, 1'b0, 1'b1, 16'h0005);
        pulse(0, 1'b0, 1'b1, 16'h0005);
        pulse(0, 1'b0, 1'b1, 16'h0006);
        pulse(1, 1'b1, 1'b1, 16'h0007);
        rxEvent[1].outOfSync <= 1'b1;
        repeat (RTT + 4) @(posedge clk);
        rxEvent[1].outOfSync <= 1'b0;
        repeat (4) @(posedge clk);
        check(lip[1], 1);
        check(lip[0], 0);
        rdcnt(0);
        rdcnt(1);
        $display("counters test done");
        for (int s = 0; s < 3; s++) begin
            rls(8'h00, 8'(s));
            exp = {ACC_CODE, 8'h00, 8'h00, 8'h00};
            for (int i = 0; i < 6; i++) exp = {exp, 8'h00, 8'h00, 8'h00, (s != 1) ? cB[i] : cA[i]};
            xact(s == 0);
        end
        rls(8'h00, 8'h03);
        pushrj(8'h0B, 8'h00);
        xact(1'b0);
        rls(8'h01, 8'h01);
        pushrj(8'h0B, 8'h00);
        xact(1'b1);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rdcnt(0);
        rdcnt(1);
        $display("status request test done");
        mkrnc(16'h0010, 8'h00, 8'h00);
        pushacc();
        xact(1'b0);
        mkrnc(16'h001C, 8'h00, 8'h00);
        msg = {msg, 8'h83, 8'h04, 8'h00, 8'h00, 8'h93, 8'h13, 8'h00, 8'h00, 8'hA3, 8'h30, 8'h00, 8'h00};
        pushacc();
        xact(1'b1);
        mkrnc(16'h0010, 8'h80, 8'h00);
        pushrj(RSN_LOGICAL, EXPL_LOGICAL);
        xact(1'b0);
        mkrnc(16'h000F, 8'h00, 8'h00);
        xact(1'b1);
        mkrnc(16'h0010, 8'h00, 8'h81);
        xact(1'b0);
        mkrnc(16'h0014, 8'h00, 8'h00);
        msg = {msg, 8'h30, 8'h04, 8'h00, 8'h00};
        xact(1'b1);
        $display("capability test done");
        tally_and_finish();
    end
endmodule : link_error_and_capability_responder_test
